// ---- rtl/esdl_defs.svh ----
`ifndef ESDL_DEFS_SVH
`define ESDL_DEFS_SVH

// register byte offsets
`define ESDL_ADR_LOG_A    8'h00
`define ESDL_ADR_LOG_B    8'h04
`define ESDL_ADR_CTRL     8'h08
`define ESDL_ADR_STATUS   8'h0c
`define ESDL_ADR_ICLR     8'h10
`define ESDL_ADR_IEN      8'h14
`define ESDL_ADR_CECNT    8'h18

// ecc_error_log layout
`define ESDL_LOG_VALID    0
`define ESDL_LOG_CE       1
`define ESDL_LOG_UE       2
`define ESDL_LOG_POISON   3
`define ESDL_LOG_OVF      4
`define ESDL_LOG_POS_LSB  8
`define ESDL_LOG_POS_MSB  14
`define ESDL_LOG_SYN_LSB  16
`define ESDL_LOG_SYN_MSB  23

// control register layout
`define ESDL_CTRL_FIX_EN  0
`define ESDL_CTRL_CLR_A   1
`define ESDL_CTRL_CLR_B   2
`define ESDL_CTRL_RESET   8'h01

// status bits per channel, three per channel
`define ESDL_ST_CE        0
`define ESDL_ST_UE        1
`define ESDL_ST_POISON    2
`define ESDL_ST_STRIDE    3

// word geometry and syndrome values
`define ESDL_DATA_BITS    64
`define ESDL_CHECK_LSB    64
`define ESDL_WORD_BITS    72
`define ESDL_SYN_NONE     8'h00
`define ESDL_SYN_POISON   8'hff

`endif

// ---- rtl/esdl_pkg.sv ----
package esdl_pkg;
  // outcome of decoding one syndrome
  typedef enum logic [1:0] {
    ESDL_KIND_NONE   = 2'b00,
    ESDL_KIND_CORR   = 2'b01,
    ESDL_KIND_UNCORR = 2'b10,
    ESDL_KIND_POISON = 2'b11
  } esdl_kind_t;
  // memory channel select
  typedef enum logic {
    ESDL_CHAN_A = 1'b0,
    ESDL_CHAN_B = 1'b1
  } esdl_chan_t;
endpackage

// ---- rtl/esdl_syn_decode.sv ----
`timescale 1ns/1ps
`include "esdl_defs.svh"
module esdl_syn_decode
  import esdl_pkg::*;
(
  input  wire logic [7:0] i_syndrome,  // syndrome from the check logic
  input  wire logic       i_poison,    // word flagged as poisoned
  output esdl_kind_t      o_kind,      // decode outcome
  output logic [6:0]      o_bit_pos    // failing word bit, 0..71
);
  // table lookup: {hit, position}; check bits by one-hot test
  function automatic logic [7:0] syn_lookup(input logic [7:0] s);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < 8; k++) begin
      if (s == (8'h01 << k)) begin
        r = {1'b1, 7'(`ESDL_CHECK_LSB + k)};
      end
    end
    unique case (s)
      8'h1c: r = {1'b1, 7'd0};
      8'ha2: r = {1'b1, 7'd1};
      8'h51: r = {1'b1, 7'd2};
      8'h0e: r = {1'b1, 7'd3};
      8'h94: r = {1'b1, 7'd4};
      8'h68: r = {1'b1, 7'd5};
      8'h43: r = {1'b1, 7'd6};
      8'hf1: r = {1'b1, 7'd7};
      8'hc1: r = {1'b1, 7'd8};
      8'h2a: r = {1'b1, 7'd9};
      8'h15: r = {1'b1, 7'd10};
      8'he0: r = {1'b1, 7'd11};
      8'h49: r = {1'b1, 7'd12};
      8'h86: r = {1'b1, 7'd13};
      8'h34: r = {1'b1, 7'd14};
      8'h1f: r = {1'b1, 7'd15};
      8'h2c: r = {1'b1, 7'd16};
      8'ha4: r = {1'b1, 7'd17};
      8'h52: r = {1'b1, 7'd18};
      8'hd0: r = {1'b1, 7'd19};
      8'h98: r = {1'b1, 7'd20};
      8'h61: r = {1'b1, 7'd21};
      8'h83: r = {1'b1, 7'd22};
      8'h2f: r = {1'b1, 7'd23};
      8'hc2: r = {1'b1, 7'd24};
      8'h4a: r = {1'b1, 7'd25};
      8'h25: r = {1'b1, 7'd26};
      8'h0d: r = {1'b1, 7'd27};
      8'h89: r = {1'b1, 7'd28};
      8'h16: r = {1'b1, 7'd29};
      8'h38: r = {1'b1, 7'd30};
      8'hf2: r = {1'b1, 7'd31};
      8'h4c: r = {1'b1, 7'd32};
      8'ha8: r = {1'b1, 7'd33};
      8'h54: r = {1'b1, 7'd34};
      8'hf8: r = {1'b1, 7'd35};
      8'h0b: r = {1'b1, 7'd36};
      8'h91: r = {1'b1, 7'd37};
      8'h62: r = {1'b1, 7'd38};
      8'h23: r = {1'b1, 7'd39};
      8'hc4: r = {1'b1, 7'd40};
      8'h8a: r = {1'b1, 7'd41};
      8'h45: r = {1'b1, 7'd42};
      8'h8f: r = {1'b1, 7'd43};
      8'hb0: r = {1'b1, 7'd44};
      8'h19: r = {1'b1, 7'd45};
      8'h26: r = {1'b1, 7'd46};
      8'h32: r = {1'b1, 7'd47};
      8'h8c: r = {1'b1, 7'd48};
      8'ha1: r = {1'b1, 7'd49};
      8'h58: r = {1'b1, 7'd50};
      8'h4f: r = {1'b1, 7'd51};
      8'h70: r = {1'b1, 7'd52};
      8'h92: r = {1'b1, 7'd53};
      8'h64: r = {1'b1, 7'd54};
      8'h13: r = {1'b1, 7'd55};
      8'hc8: r = {1'b1, 7'd56};
      8'h1a: r = {1'b1, 7'd57};
      8'h85: r = {1'b1, 7'd58};
      8'hf4: r = {1'b1, 7'd59};
      8'h07: r = {1'b1, 7'd60};
      8'h29: r = {1'b1, 7'd61};
      8'h46: r = {1'b1, 7'd62};
      8'h31: r = {1'b1, 7'd63};
      default: r = r;  // check-bit result or miss stands
    endcase
    return r;
  endfunction

  logic [7:0] hit_pos;  // {hit, position}
  assign hit_pos   = syn_lookup(i_syndrome);
  assign o_bit_pos = hit_pos[6:0];
  // poison first, then clean, then table hit, else multi-bit
  assign o_kind = (i_poison || i_syndrome == `ESDL_SYN_POISON) ? ESDL_KIND_POISON :
                  (i_syndrome == `ESDL_SYN_NONE)                ? ESDL_KIND_NONE :
                  hit_pos[7]                                    ? ESDL_KIND_CORR :
                                                                  ESDL_KIND_UNCORR;
endmodule

// ---- rtl/esdl_bit_fix.sv ----
`timescale 1ns/1ps
`include "esdl_defs.svh"
module esdl_bit_fix #(
  parameter int WORD_BITS = `ESDL_WORD_BITS  // data plus check bits
) (
  input  wire logic [WORD_BITS-1:0] i_word,     // raw channel word
  input  wire logic                 i_flip_en,  // flip one bit
  input  wire logic [6:0]           i_bit_pos,  // which bit to flip
  output logic      [WORD_BITS-1:0] o_word      // corrected word
);
  // one xor per bit; check bits 71:64 are fixed like data
  for (genvar g = 0; g < WORD_BITS; g++) begin : g_flip
    assign o_word[g] = i_word[g] ^ (i_flip_en && i_bit_pos == 7'(g));
  end
endmodule

// ---- rtl/esdl_ecc_log.sv ----
`timescale 1ns/1ps
`include "esdl_defs.svh"
module esdl_ecc_log
  import esdl_pkg::*;
#(
  parameter int WORD_BITS = `ESDL_WORD_BITS,  // channel word width
  parameter int CNT_BITS  = 16                // per-channel ce counter
) (
  input  wire logic                 i_ref_clk,        // 25 MHz controller clock
  input  wire logic                 i_nrst,           // async reset, active low
  // classic wishbone slave
  input  wire logic                 i_wb_cyc,         // bus cycle
  input  wire logic                 i_wb_stb,         // strobe
  input  wire logic                 i_wb_we,          // write enable
  input  wire logic [7:0]           i_wb_adr,         // byte address
  input  wire logic [3:0]           i_wb_sel,         // byte enables
  input  wire logic [31:0]          i_wb_dat,         // write data
  output logic      [31:0]          o_wb_dat,         // read data
  output logic                      o_wb_ack,         // acknowledge
  // read words from the memory channels
  input  wire logic                 i_rd_valid,       // word present
  input  wire logic                 i_rd_chan,        // 0 channel a, 1 channel b
  input  wire logic [WORD_BITS-1:0] i_rd_word,        // data 63:0, checks 71:64
  input  wire logic [7:0]           i_rd_syndrome,    // syndrome of that word
  input  wire logic                 i_rd_poison,      // word marked poisoned
  // corrected words, one cycle later
  output logic                      o_fix_valid,      // word present
  output logic                      o_fix_chan,       // its channel
  output logic      [WORD_BITS-1:0] o_fix_word,       // word after correction
  output logic                      o_fix_corrected,  // a single bit was fixed
  output logic                      o_fix_uncorr,     // multi-bit, left as read
  output logic                      o_fix_poison,     // poisoned word
  output logic                      o_irq             // level interrupt
);
  localparam int NCH = 2;  // channels a and b
  localparam int NST = NCH * `ESDL_ST_STRIDE;

  // reset release through two flops
  logic rst_meta;  // first stage, read only by rst_sync
  logic rst_sync;  // active-high-released copy, 1 = running

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  logic nrst_int;  // reset used by the rest of the block
  assign nrst_int = rst_sync;

  // syndrome decode of the incoming word
  esdl_kind_t dec_kind;  // decode outcome
  logic [6:0] dec_pos;   // failing bit position

  esdl_syn_decode u_decode (
    .i_syndrome (i_rd_syndrome),
    .i_poison   (i_rd_poison),
    .o_kind     (dec_kind),
    .o_bit_pos  (dec_pos)
  );

  // control register
  logic [7:0] ctrl;  // fix enable, clear strobes read back as zero
  logic       fix_en;
  assign fix_en = ctrl[`ESDL_CTRL_FIX_EN];

  // correction only when enabled and the decode named one bit
  logic                 do_flip;
  logic [WORD_BITS-1:0] flip_word;
  assign do_flip = i_rd_valid && fix_en && (dec_kind == ESDL_KIND_CORR);

  esdl_bit_fix #(
    .WORD_BITS (WORD_BITS)
  ) u_fix (
    .i_word    (i_rd_word),
    .i_flip_en (do_flip),
    .i_bit_pos (dec_pos),
    .o_word    (flip_word)
  );

  // output stage, data from flops
  always_ff @(posedge i_ref_clk or negedge nrst_int) begin
    if (!nrst_int) begin
      o_fix_valid     <= 1'b0;
      o_fix_chan      <= 1'b0;
      o_fix_word      <= '0;
      o_fix_corrected <= 1'b0;
      o_fix_uncorr    <= 1'b0;
      o_fix_poison    <= 1'b0;
    end else begin
      o_fix_valid     <= i_rd_valid;
      o_fix_chan      <= i_rd_chan;
      o_fix_word      <= flip_word;
      o_fix_corrected <= do_flip;
      o_fix_uncorr    <= i_rd_valid && (dec_kind == ESDL_KIND_UNCORR);
      o_fix_poison    <= i_rd_valid && (dec_kind == ESDL_KIND_POISON);
    end
  end

  // bus decode, all named wires
  logic bus_req;      // request on the bus
  logic bus_commit;   // edge where the master samples ack
  logic wr_commit;    // write takes effect here
  logic hit_log_a;
  logic hit_log_b;
  logic hit_ctrl;
  logic hit_status;
  logic hit_iclr;
  logic hit_ien;
  logic hit_cecnt;
  assign bus_req    = i_wb_cyc && i_wb_stb;
  assign bus_commit = bus_req && o_wb_ack;
  assign wr_commit  = bus_commit && i_wb_we && i_wb_sel[0];
  assign hit_log_a  = (i_wb_adr == `ESDL_ADR_LOG_A);
  assign hit_log_b  = (i_wb_adr == `ESDL_ADR_LOG_B);
  assign hit_ctrl   = (i_wb_adr == `ESDL_ADR_CTRL);
  assign hit_status = (i_wb_adr == `ESDL_ADR_STATUS);
  assign hit_iclr   = (i_wb_adr == `ESDL_ADR_ICLR);
  assign hit_ien    = (i_wb_adr == `ESDL_ADR_IEN);
  assign hit_cecnt  = (i_wb_adr == `ESDL_ADR_CECNT);

  // clear strobes from a control write
  logic [NCH-1:0] log_clr;  // per-channel log clear pulse
  assign log_clr[0] = wr_commit && hit_ctrl && i_wb_dat[`ESDL_CTRL_CLR_A];
  assign log_clr[1] = wr_commit && hit_ctrl && i_wb_dat[`ESDL_CTRL_CLR_B];

  always_ff @(posedge i_ref_clk or negedge nrst_int) begin
    if (!nrst_int) begin
      ctrl <= `ESDL_CTRL_RESET;
    end else if (wr_commit && hit_ctrl) begin
      ctrl <= {7'h00, i_wb_dat[`ESDL_CTRL_FIX_EN]};  // strobe bits never stored
    end
  end

  // per-channel error events and logs
  logic [31:0]        err_log [NCH];  // ecc_error_log per channel
  logic [CNT_BITS-1:0] ce_cnt [NCH];  // saturating correctable count
  logic [NST-1:0]     ev_bits;        // this cycle's events, status layout

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    logic ev_any;     // a logged error on this channel
    logic ev_ce;
    logic ev_ue;
    logic ev_poison;
    logic [7:0]  log_syn;   // syndrome to store
    logic [31:0] next_log;  // fresh log word

    assign ev_any    = i_rd_valid && (i_rd_chan == 1'(c)) && (dec_kind != ESDL_KIND_NONE);
    assign ev_ce     = ev_any && (dec_kind == ESDL_KIND_CORR);
    assign ev_ue     = ev_any && (dec_kind == ESDL_KIND_UNCORR);
    assign ev_poison = ev_any && (dec_kind == ESDL_KIND_POISON);
    // poisoned words log all ones whatever syndrome came in
    assign log_syn   = ev_poison ? `ESDL_SYN_POISON : i_rd_syndrome;

    always_comb begin
      next_log = 32'h0000_0000;
      next_log[`ESDL_LOG_SYN_MSB:`ESDL_LOG_SYN_LSB] = log_syn;
      next_log[`ESDL_LOG_POS_MSB:`ESDL_LOG_POS_LSB] = ev_ce ? dec_pos : 7'h00;
      next_log[`ESDL_LOG_VALID]  = 1'b1;
      next_log[`ESDL_LOG_CE]     = ev_ce;
      next_log[`ESDL_LOG_UE]     = ev_ue;
      next_log[`ESDL_LOG_POISON] = ev_poison;
    end

    assign ev_bits[c*`ESDL_ST_STRIDE + `ESDL_ST_CE]     = ev_ce;
    assign ev_bits[c*`ESDL_ST_STRIDE + `ESDL_ST_UE]     = ev_ue;
    assign ev_bits[c*`ESDL_ST_STRIDE + `ESDL_ST_POISON] = ev_poison;

    // first error is kept; later ones only set overflow until cleared.
    // an event in the clear cycle loads fresh so it is not lost
    always_ff @(posedge i_ref_clk or negedge nrst_int) begin
      if (!nrst_int) begin
        err_log[c] <= 32'h0000_0000;
      end else if (ev_any && (log_clr[c] || !err_log[c][`ESDL_LOG_VALID])) begin
        err_log[c] <= next_log;
      end else if (log_clr[c]) begin
        err_log[c] <= 32'h0000_0000;
      end else if (ev_any) begin
        err_log[c][`ESDL_LOG_OVF] <= 1'b1;
      end
    end

    // counter saturates rather than wraps, so a storm stays visible
    always_ff @(posedge i_ref_clk or negedge nrst_int) begin
      if (!nrst_int) begin
        ce_cnt[c] <= '0;
      end else if (log_clr[c]) begin
        ce_cnt[c] <= ev_ce ? CNT_BITS'(1) : '0;
      end else if (ev_ce && (ce_cnt[c] != '1)) begin
        ce_cnt[c] <= ce_cnt[c] + CNT_BITS'(1);
      end
    end
  end

  // interrupt status, clear and enable
  logic [NST-1:0] irq_status;  // sticky events
  logic [NST-1:0] irq_en;      // enable mask
  logic [NST-1:0] irq_clr;     // write-only clear, this cycle
  assign irq_clr = (wr_commit && hit_iclr) ? i_wb_dat[NST-1:0] : '0;
  logic [NST-1:0] next_irq_en; // enable as it stands after this edge
  assign next_irq_en = (wr_commit && hit_ien) ? i_wb_dat[NST-1:0] : irq_en;

  // shared by the status flops and the interrupt level
  function automatic logic [NST-1:0] next_irq_status();
    return (irq_status & ~irq_clr) | ev_bits;
  endfunction

  always_ff @(posedge i_ref_clk or negedge nrst_int) begin
    if (!nrst_int) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status();  // set beats clear
    end
  end

  always_ff @(posedge i_ref_clk or negedge nrst_int) begin
    if (!nrst_int) begin
      irq_en <= '0;
    end else begin
      irq_en <= next_irq_en;
    end
  end

  // level output, high while an enabled bit stands
  always_ff @(posedge i_ref_clk or negedge nrst_int) begin
    if (!nrst_int) begin
      o_irq <= 1'b0;
    end else begin
      // next values on both sides, so an enable write shows without lag
      o_irq <= |(next_irq_status() & next_irq_en);
    end
  end

  // read mux; unmapped and write-only addresses read zero
  logic [31:0] rd_mux;
  logic [31:0] cnt_word;
  assign cnt_word = {16'(ce_cnt[1]), 16'(ce_cnt[0])};
  assign rd_mux = hit_log_a  ? err_log[0] :
                  hit_log_b  ? err_log[1] :
                  hit_ctrl   ? {24'h000000, ctrl} :
                  hit_status ? {{(32-NST){1'b0}}, irq_status} :
                  hit_ien    ? {{(32-NST){1'b0}}, irq_en} :
                  hit_cecnt  ? cnt_word :
                               32'h0000_0000;

  // one wait state: ack the cycle after the request, drop it after
  always_ff @(posedge i_ref_clk or negedge nrst_int) begin
    if (!nrst_int) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req && !o_wb_ack;
      o_wb_dat <= (bus_req && !o_wb_ack && !i_wb_we) ? rd_mux : 32'h0000_0000;
    end
  end
endmodule

// ---- testbench/esdl_ecc_log_props.sv ----
`timescale 1ns/1ps
// port-level watch of the log block: bus timing and per-word decode outcome
module esdl_ecc_log_props #(
  parameter int WORD_BITS = 72,  // channel word width
  parameter int CNT_BITS  = 16   // ce counter width
) (
  input wire logic                 i_ref_clk,
  input wire logic                 i_nrst,
  input wire logic                 i_wb_cyc,
  input wire logic                 i_wb_stb,
  input wire logic                 i_wb_we,
  input wire logic [7:0]           i_wb_adr,
  input wire logic [3:0]           i_wb_sel,
  input wire logic [31:0]          i_wb_dat,
  input wire logic [31:0]          o_wb_dat,
  input wire logic                 o_wb_ack,
  input wire logic                 i_rd_valid,
  input wire logic                 i_rd_chan,
  input wire logic [WORD_BITS-1:0] i_rd_word,
  input wire logic [7:0]           i_rd_syndrome,
  input wire logic                 i_rd_poison,
  input wire logic                 o_fix_valid,
  input wire logic                 o_fix_chan,
  input wire logic [WORD_BITS-1:0] o_fix_word,
  input wire logic                 o_fix_corrected,
  input wire logic                 o_fix_uncorr,
  input wire logic                 o_fix_poison,
  input wire logic                 o_irq
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  // bus request not yet answered
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  // answer is a single-cycle pulse
  sequence s_ack;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  // clean word with a given syndrome
  sequence s_word(logic [7:0] s);
    i_rd_valid && !i_rd_poison && i_rd_syndrome == s;
  endsequence
  // exactly the mask flipped when corrected, nothing otherwise
  sequence s_flip(logic [71:0] m);
    !o_fix_uncorr && (o_fix_word ^ $past(i_rd_word)) == (o_fix_corrected ? m : 72'h0);
  endsequence

  property p_ack;
    s_req |=> s_ack;
  endproperty
  property p_dat;
    !o_wb_ack |-> o_wb_dat == 32'h0;
  endproperty
  property p_chan;
    i_rd_valid |=> o_fix_valid && o_fix_chan == $past(i_rd_chan);
  endproperty
  property p_zero;
    s_word(8'h00) |=> !o_fix_corrected && !o_fix_uncorr && !o_fix_poison && o_fix_word == $past(i_rd_word);
  endproperty
  property p_poison;
    i_rd_valid && (i_rd_poison || i_rd_syndrome == 8'hff) |=> o_fix_poison && !o_fix_corrected && !o_fix_uncorr;
  endproperty
  property p_check;
    i_rd_valid && !i_rd_poison && $onehot(i_rd_syndrome) |=>
      !o_fix_uncorr && (o_fix_word ^ $past(i_rd_word)) == (o_fix_corrected ? {$past(i_rd_syndrome), 64'h0} : 72'h0);
  endproperty
  property p_bit0;
    s_word(8'h1c) |=> s_flip(72'h1);
  endproperty
  property p_bit38;
    s_word(8'h62) |=> s_flip(72'h40_0000_0000);
  endproperty
  property p_unc;
    s_word(8'h03) |=> o_fix_uncorr && !o_fix_corrected && o_fix_word == $past(i_rd_word);
  endproperty
  // irq rises only from a word event or a register write
  property p_irq;
    $rose(o_irq) |-> $past(i_rd_valid) || $past(o_wb_ack && i_wb_we);
  endproperty

  a_ack: assert property (p_ack) else $error("ack not a one-cycle pulse after request");
  a_dat: assert property (p_dat) else $error("read data nonzero without ack");
  a_chan: assert property (p_chan) else $error("fixed word valid or channel wrong");
  a_zero: assert property (p_zero) else $error("zero syndrome altered the word");
  a_poison: assert property (p_poison) else $error("poisoned word not flagged");
  a_check: assert property (p_check) else $error("check bit syndrome flipped wrong bit");
  a_bit0: assert property (p_bit0) else $error("syndrome 1c did not flip data bit 0");
  a_bit38: assert property (p_bit38) else $error("syndrome 62 did not flip data bit 38");
  a_unc: assert property (p_unc) else $error("unlisted syndrome not left uncorrected");
  a_irq: assert property (p_irq) else $error("irq rose without cause");
endmodule

// ---- testbench/esdl_mem_model.sv ----
`timescale 1ns/1ps
// far side of both channels: hands the block a read word and its syndrome
module esdl_mem_model (
  input  wire logic        i_clk,       // controller clock
  output logic             o_valid,     // word present
  output logic             o_chan,      // channel a or b
  output logic [71:0]      o_word,      // data 63:0, checks 71:64
  output logic [7:0]       o_syndrome,  // syndrome of the word
  output logic             o_poison     // word marked poisoned
);
  // idle at time zero
  initial begin
    o_valid    = 1'b0;
    o_chan     = 1'b0;
    o_word     = 72'h0;
    o_syndrome = 8'h00;
    o_poison   = 1'b0;
  end
  // one word per call: launched after an edge, taken at the next
  task automatic send(input logic ch, input logic [7:0] syn, input logic poi, input logic [71:0] w);
    @(posedge i_clk);
    o_valid    <= 1'b1;
    o_chan     <= ch;
    o_word     <= w;
    o_syndrome <= syn;
    o_poison   <= poi;
    @(posedge i_clk);
    // released word and syndrome show the inverse so a stale word cannot pass
    o_valid    <= 1'b0;
    o_word     <= ~w;
    o_syndrome <= ~syn;
    o_poison   <= 1'b0;
  endtask
endmodule

// ---- testbench/esdl_ecc_log_tb.sv ----
`timescale 1ns/1ps
`include "esdl_defs.svh"
module esdl_ecc_log_tb;
  localparam logic [71:0]  W    = {8'ha5, 64'h0123_4567_89ab_cdef};  // base word
  // data syndromes and their bit positions, first entry in the top byte
  localparam logic [191:0] DSYN = {8'h1c, 8'ha2, 8'h51, 8'h0e, 8'h94, 8'h68, 8'h43, 8'hf1, 8'hf2, 8'hf4, 8'hf8,
    8'hc1, 8'hc2, 8'hc4, 8'hc8, 8'h61, 8'h62, 8'h07, 8'h0b, 8'h0d, 8'h13, 8'h15, 8'h16, 8'h19};
  localparam logic [191:0] DPOS = {8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h1f, 8'h3b, 8'h23,
    8'h08, 8'h18, 8'h28, 8'h38, 8'h15, 8'h26, 8'h3c, 8'h24, 8'h1b, 8'h37, 8'h0a, 8'h1d, 8'h2d};
  logic        i_ref_clk = 1'b0;  // 25 mhz
  logic        i_nrst    = 1'b0;  // held low at start
  logic        i_wb_cyc  = 1'b0;
  logic        i_wb_stb  = 1'b0;
  logic        i_wb_we   = 1'b0;
  logic [7:0]  i_wb_adr  = 8'h00;
  logic [3:0]  i_wb_sel  = 4'h0;
  logic [31:0] i_wb_dat  = 32'h0;
  logic        i_rd_valid, i_rd_chan, i_rd_poison;
  logic [71:0] i_rd_word, o_fix_word;
  logic [7:0]  i_rd_syndrome;
  logic [31:0] o_wb_dat;
  logic        o_wb_ack, o_fix_valid, o_fix_chan, o_fix_corrected, o_fix_uncorr, o_fix_poison, o_irq;
  int          err_count = 0;  // mismatches
  int          checks    = 0;  // comparisons made

  always #20 i_ref_clk = ~i_ref_clk;

  esdl_mem_model mem (.i_clk(i_ref_clk), .o_valid(i_rd_valid), .o_chan(i_rd_chan), .o_word(i_rd_word),
    .o_syndrome(i_rd_syndrome), .o_poison(i_rd_poison));
  esdl_ecc_log DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_rd_valid(i_rd_valid), .i_rd_chan(i_rd_chan), .i_rd_word(i_rd_word),
    .i_rd_syndrome(i_rd_syndrome), .i_rd_poison(i_rd_poison), .o_fix_valid(o_fix_valid),
    .o_fix_chan(o_fix_chan), .o_fix_word(o_fix_word), .o_fix_corrected(o_fix_corrected),
    .o_fix_uncorr(o_fix_uncorr), .o_fix_poison(o_fix_poison), .o_irq(o_irq));

  // single exit point with the verdict
  task automatic results();
    $display("mismatches %0d, checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [71:0] got, input logic [71:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  // classic single cycle; waits for ack under a bound
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    @(posedge i_ref_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= adr;
    i_wb_sel <= 4'hf;
    i_wb_dat <= dat;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 16);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we  <= 1'b0;
    if (o_wb_ack !== 1'b1) begin
      err_count++;
      $display("BAD wb_ack exp 1 got %b", o_wb_ack);
      results();
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] v;
    wb(1'b1, adr, dat, v);
  endtask
  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string name);
    logic [31:0] v;
    wb(1'b0, adr, 32'h0, v);
    chk(name, 72'(v), 72'(exp));
  endtask
  function automatic logic [31:0] logv(input logic [7:0] syn, input logic [6:0] pos, input logic [4:0] fl);
    return {8'h00, syn, 1'b0, pos, 3'h0, fl};
  endfunction
  // flags: valid, chan, corrected, uncorr, poison
  task automatic word(input logic ch, input logic [7:0] syn, input logic poi, input logic [71:0] exp,
                      input logic [4:0] fl);
    mem.send(ch, syn, poi, W);
    #1;
    chk("fix_word", o_fix_word, exp);
    chk("fix_flags", 72'({o_fix_valid, o_fix_chan, o_fix_corrected, o_fix_uncorr, o_fix_poison}), 72'(fl));
  endtask
  // one correctable error, its log entry, then log clear
  task automatic t_bit(input logic [7:0] syn, input logic [6:0] pos, input logic ch);
    word(ch, syn, 1'b0, W ^ (72'h1 << pos), {1'b1, ch, 3'b100});
    rdchk(ch ? `ESDL_ADR_LOG_B : `ESDL_ADR_LOG_A, logv(syn, pos, 5'h03), "log");
    wr(`ESDL_ADR_CTRL, ch ? 32'h5 : 32'h3);
  endtask
  task automatic t_range(input int lo, input int hi);
    for (int k = lo; k <= hi; k++) begin
      t_bit(DSYN[191-8*k -: 8], DPOS[190-8*k -: 7], k[0]);
    end
  endtask
  task automatic t_regs();
    rdchk(`ESDL_ADR_CTRL, 32'h1, "ctrl");
    rdchk(`ESDL_ADR_LOG_B, 32'h0, "log_b");
    rdchk(`ESDL_ADR_STATUS, 32'h0, "status");
    rdchk(`ESDL_ADR_CECNT, 32'h0, "cecnt");
    wr(`ESDL_ADR_LOG_A, 32'hffff_ffff);
    rdchk(`ESDL_ADR_LOG_A, 32'h0, "log_ro");
    rdchk(8'h1c, 32'h0, "unmapped");
    rdchk(`ESDL_ADR_ICLR, 32'h0, "iclr");
  endtask
  // zero, unlisted and poison syndromes
  task automatic t_odd();
    wr(`ESDL_ADR_ICLR, 32'h3f);
    word(1'b0, 8'h00, 1'b0, W, 5'b10000);
    rdchk(`ESDL_ADR_LOG_A, 32'h0, "log_zero");
    rdchk(`ESDL_ADR_STATUS, 32'h0, "st_zero");
    word(1'b1, 8'h03, 1'b0, W, 5'b11010);
    rdchk(`ESDL_ADR_LOG_B, logv(8'h03, 7'h0, 5'h05), "log_ue");
    rdchk(`ESDL_ADR_STATUS, 32'h10, "st_ue");
    wr(`ESDL_ADR_CTRL, 32'h5);
    word(1'b1, 8'h37, 1'b1, W, 5'b11001);
    rdchk(`ESDL_ADR_LOG_B, logv(8'hff, 7'h0, 5'h09), "log_poi_b");
    word(1'b0, 8'hff, 1'b0, W, 5'b10001);
    rdchk(`ESDL_ADR_LOG_A, logv(8'hff, 7'h0, 5'h09), "log_poi_a");
    wr(`ESDL_ADR_CTRL, 32'h7);
  endtask
  // enable, mask, overflow, counts and clear of the interrupt
  task automatic t_irq();
    wr(`ESDL_ADR_ICLR, 32'h3f);
    wr(`ESDL_ADR_IEN, 32'h1);
    rdchk(`ESDL_ADR_IEN, 32'h1, "ien");
    word(1'b0, 8'h1c, 1'b0, W ^ 72'h1, 5'b10100);
    chk("irq_set", 72'(o_irq), 72'h1);
    word(1'b1, 8'h0e, 1'b0, W ^ 72'h8, 5'b11100);
    word(1'b0, 8'h51, 1'b0, W ^ 72'h4, 5'b10100);
    rdchk(`ESDL_ADR_LOG_A, logv(8'h1c, 7'h0, 5'h13), "log_ovf");
    rdchk(`ESDL_ADR_STATUS, 32'h9, "status");
    rdchk(`ESDL_ADR_CECNT, 32'h0001_0002, "cecnt");
    wr(`ESDL_ADR_ICLR, 32'h1);
    rdchk(`ESDL_ADR_STATUS, 32'h8, "st_clr");
    chk("irq_masked", 72'(o_irq), 72'h0);
    wr(`ESDL_ADR_IEN, 32'h9);
    rdchk(`ESDL_ADR_IEN, 32'h9, "ien_b");
    chk("irq_en_wr", 72'(o_irq), 72'h1);
    wr(`ESDL_ADR_CTRL, 32'h7);
  endtask
  // correction off: word passes unchanged but is still logged
  task automatic t_nofix();
    wr(`ESDL_ADR_CTRL, 32'h0);
    rdchk(`ESDL_ADR_CTRL, 32'h0, "ctrl_off");
    word(1'b0, 8'h62, 1'b0, W, 5'b10000);
    rdchk(`ESDL_ADR_LOG_A, logv(8'h62, 7'h26, 5'h03), "log_nofix");
    wr(`ESDL_ADR_CTRL, 32'h3);
    rdchk(`ESDL_ADR_CTRL, 32'h1, "ctrl_strobe");
  endtask

  // main sequence: reset, then scenarios
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    t_regs();
    for (int i = 0; i < 8; i++) begin
      t_bit(8'h01 << i, 7'(64 + i), i[0]);
    end
    t_range(0, 7);
    t_range(8, 14);
    t_range(15, 16);
    t_range(17, 23);
    t_odd();
    t_irq();
    t_nofix();
    results();
  end
endmodule

bind esdl_ecc_log esdl_ecc_log_props #(.WORD_BITS(WORD_BITS), .CNT_BITS(CNT_BITS)) u_props (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_rd_valid(i_rd_valid), .i_rd_chan(i_rd_chan), .i_rd_word(i_rd_word), .i_rd_syndrome(i_rd_syndrome),
  .i_rd_poison(i_rd_poison), .o_fix_valid(o_fix_valid), .o_fix_chan(o_fix_chan), .o_fix_word(o_fix_word),
  .o_fix_corrected(o_fix_corrected), .o_fix_uncorr(o_fix_uncorr), .o_fix_poison(o_fix_poison), .o_irq(o_irq));
